/* File: design/half_bridge_pwm.v */
// 10-bit pwm generator with single and half-bridge complementary outputs
// assumes synchronous control ports written by a cpu; clock is the oscillator
// assumes sleep and timer_run_enable are levels held by the cpu, not pulses
// assumes the pins see the outputs only through the oe and owned ports
`include "pwm_defs.vh"
module half_bridge_pwm #(
	parameter DB_W = 7
) (
	input wire clock,
	input wire nrst,
	input wire sleep,
	input wire [7:0] period_limit,
	input wire [7:0] duty_msb_reg,
	input wire [7:0] ccp_control,
	input wire [DB_W-1:0] deadband_count,
	input wire [1:0] timer_prescale_sel,
	input wire timer_run_enable,
	input wire timer_flag_clear,
	input wire [1:0] pin_direction,
	output reg [7:0] base_timer_count,
	output reg [7:0] duty_shadow,
	output reg timer_period_flag,
	output wire output_a,
	output wire output_a_oe,
	output wire output_b,
	output wire output_b_oe,
	output wire output_a_owned,
	output wire output_b_owned
);
	// -------------------------------------------------
	// decoded control
	// -------------------------------------------------
	wire [1:0] output_mode_sel;
	wire [1:0] duty_lsb_bits;
	wire [3:0] ccp_mode_bits;
	reg pwm_on;
	reg half_mode;
	assign output_mode_sel = ccp_control[`CCP_MODE_SEL_HI:`CCP_MODE_SEL_LO];
	assign duty_lsb_bits = ccp_control[`CCP_DUTY_LSB_HI:`CCP_DUTY_LSB_LO];
	assign ccp_mode_bits = ccp_control[`CCP_MODE_BITS_HI:`CCP_MODE_BITS_LO];
	// pwm modes are 11xx; the low two bits carry polarity
	always @* begin
		pwm_on = (ccp_mode_bits[3:2] == `CCP_PWM_MODE);
		case (output_mode_sel)
			`MODE_SINGLE: begin
				half_mode = 1'b0;
			end
			`MODE_HALF: begin
				half_mode = 1'b1;
			end
			default: begin
				half_mode = 1'b0; // unlisted codes behave as single
			end
		endcase
	end
	// -------------------------------------------------
	// oscillator phase and prescaler
	// -------------------------------------------------
	reg [3:0] phase_reg;
	reg [3:0] phase_next;
	reg [3:0] phase_top;
	wire run;
	wire step;
	wire tcy_tick;
	reg [1:0] sub_bits;
	// whole block is gated by sleep so state freezes in place
	assign run = !sleep && timer_run_enable;
	// -------------------------------------------------
	// prescale decode
	// -------------------------------------------------
	// prescale top count: 4, 16 or 64 oscillator periods per timer step
	always @* begin
		case (timer_prescale_sel)
			`PRESCALE_1: begin
				phase_top = 4'h3;
			end
			`PRESCALE_4: begin
				phase_top = 4'hf;
			end
			default: begin
				phase_top = 4'hf;
			end
		endcase
	end
	reg [1:0] pre16_reg;
	// x16 needs two extra bits above the 4-bit phase counter
	wire wrap_phase;
	assign wrap_phase = (phase_reg == phase_top);
	// a phase left above a smaller top runs on to the wrap, never stepping early
	always @* begin
		if (wrap_phase) begin
			phase_next = `PHASE_RST;
		end else begin
			phase_next = phase_reg + 4'h1;
		end
	end
	// phase counter only runs with the timer
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= `PHASE_RST;
		end else if (run) begin
			phase_reg <= phase_next;
		end
	end
	// x16 extension steps once per phase wrap
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pre16_reg <= 2'h0;
		end else if (run && wrap_phase && timer_prescale_sel[1]) begin
			pre16_reg <= pre16_reg + 2'h1;
		end
	end
	// timer steps once per 4*prescale oscillator periods; no postscaler here
	assign step = run && wrap_phase && (!timer_prescale_sel[1] || pre16_reg == 2'h3);
	// tick marks the last clock of each instruction cycle while the timer runs; phase_reg freezes with timer_run_enable low, and the tick with it
	assign tcy_tick = !sleep && (phase_reg[1:0] == 2'h3);
	// -------------------------------------------------
	// low time-base bits
	// -------------------------------------------------
	// osc phase at 1:1, prescaler bits otherwise
	always @* begin
		case (timer_prescale_sel)
			`PRESCALE_1: begin
				sub_bits = phase_reg[1:0];
			end
			`PRESCALE_4: begin
				sub_bits = phase_reg[3:2];
			end
			default: begin
				sub_bits = pre16_reg;
			end
		endcase
	end
	// -------------------------------------------------
	// period timer, shadow duty and flag
	// -------------------------------------------------
	reg [1:0] duty_latch_reg;
	reg started_reg;
	reg raw_reg;
	reg [7:0] count_next;
	reg flag_next;
	reg [7:0] shadow_next;
	reg [1:0] duty_latch_next;
	reg started_next;
	reg raw_next;
	wire rollover;
	wire [9:0] time_base;
	wire [9:0] duty_value;
	wire [9:0] duty_active;
	wire duty_zero;
	wire duty_hit;
	wire raw_live;
	// the limit match only counts on a prescaled step
	assign rollover = step && (base_timer_count == period_limit);
	assign time_base = {base_timer_count, sub_bits};
	assign duty_value = {duty_msb_reg, duty_lsb_bits};
	assign duty_active = {duty_shadow, duty_latch_reg};
	assign duty_zero = (duty_value == 10'h000);
	// -------------------------------------------------
	// period counter and flag
	// -------------------------------------------------
	// counter restarts at the limit; the flag's set wins over a same-cycle clear
	always @* begin
		count_next = base_timer_count;
		flag_next = timer_period_flag;
		if (rollover) begin
			count_next = 8'h00;
			flag_next = 1'b1;
		end else begin
			if (step) begin
				count_next = base_timer_count + 8'h01;
			end
			if (timer_flag_clear) begin
				flag_next = 1'b0;
			end
		end
	end
	// counter and flag registers
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			base_timer_count <= 8'h00;
			timer_period_flag <= 1'b0;
		end else begin
			base_timer_count <= count_next;
			timer_period_flag <= flag_next;
		end
	end
	// -------------------------------------------------
	// duty double buffer and start gate
	// -------------------------------------------------
	// shadow only loads at rollover; software has no write path
	always @* begin
		shadow_next = duty_shadow;
		duty_latch_next = duty_latch_reg;
		started_next = started_reg;
		if (rollover) begin
			shadow_next = duty_msb_reg;
			duty_latch_next = duty_lsb_bits;
			started_next = pwm_on;
		end else if (!pwm_on) begin
			started_next = 1'b0;
		end
	end
	// leaving pwm mode re-arms the wait, so re-entry never shows a partial period
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			duty_shadow <= 8'h00;
			duty_latch_reg <= 2'h0;
			started_reg <= 1'b0;
		end else begin
			duty_shadow <= shadow_next;
			duty_latch_reg <= duty_latch_next;
			started_reg <= started_next;
		end
	end
	// -------------------------------------------------
	// raw waveform
	// -------------------------------------------------
	// a duty beyond the period never matches, so the output holds
	assign duty_hit = started_reg && (time_base == duty_active);
	// a registered clear lands one edge late; the live level masks the hit
	assign raw_live = raw_reg && !duty_hit;
	// zero duty never sets; off mode forces low and waits for a rollover
	always @* begin
		raw_next = raw_reg;
		if (!pwm_on) begin
			raw_next = 1'b0;
		end else if (rollover) begin
			raw_next = !duty_zero;
		end else if (run && duty_hit) begin
			raw_next = 1'b0;
		end
	end
	// held in sleep since run is low and no rollover can occur
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			raw_reg <= 1'b0;
		end else begin
			raw_reg <= raw_next;
		end
	end
	// -------------------------------------------------
	// dead-band and polarity
	// -------------------------------------------------
	wire db_a;
	wire db_b;
	wire raw_b;
	wire run_db;
	wire sig_a;
	wire sig_b;
	wire raw_b_gated;
	wire [DB_W-1:0] delay_a_count;
	assign run_db = !sleep;
	assign raw_b = started_reg && !raw_live;
	// b only toggles in half-bridge; single mode keeps its delay line idle
	assign raw_b_gated = raw_b && half_mode;
	// a takes no delay outside half-bridge mode
	assign delay_a_count = half_mode ? deadband_count : {DB_W{1'b0}};
	// output a dead-band
	deadband_delay #(.W(DB_W)) delay_a (
		.clock(clock),
		.nrst(nrst),
		.run(run_db),
		.tick(tcy_tick),
		.delay(delay_a_count),
		.raw(raw_live),
		.out(db_a)
	);
	deadband_delay #(.W(DB_W)) delay_b (
		.clock(clock),
		.nrst(nrst),
		.run(run_db),
		.tick(tcy_tick),
		.delay(deadband_count),
		.raw(raw_b_gated),
		.out(db_b)
	);
	// half-bridge output b uses its own dead-band; single mode mirrors a
	assign sig_a = half_mode ? db_a : raw_live;
	assign sig_b = half_mode ? db_b : raw_live;
	// mode bit 1 inverts a, bit 0 inverts b (set means active low)
	reg out_a_reg;
	reg out_b_reg;
	// a holds its level in sleep
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_a_reg <= 1'b0;
		end else if (!sleep) begin
			out_a_reg <= sig_a ^ ccp_mode_bits[1];
		end
	end
	// b likewise, after the dead-band so delay stays on the active edge
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_b_reg <= 1'b0;
		end else if (!sleep) begin
			out_b_reg <= sig_b ^ ccp_mode_bits[0];
		end
	end
	assign output_a = out_a_reg;
	assign output_b = out_b_reg;
	// -------------------------------------------------
	// pin ownership and drivers
	// -------------------------------------------------
	// pin_direction bit set means input; reset value of the port is input
	wire own_b_mode;
	wire dir_a_out;
	wire dir_b_out;
	// b belongs to the module only in half-bridge; single leaves it free
	assign own_b_mode = half_mode;
	// a cleared direction bit is the only way software opens a driver
	assign dir_a_out = !pin_direction[0];
	assign dir_b_out = !pin_direction[1];
	// a cleared control word releases both pins at once
	assign output_a_owned = pwm_on;
	assign output_b_owned = pwm_on && own_b_mode;
	// reset forces both drivers off while it is held
	assign output_a_oe = output_a_owned && dir_a_out && nrst;
	assign output_b_oe = output_b_owned && dir_b_out && nrst;
endmodule // half_bridge_pwm

/* File: design/pwm_defs.vh */
// constants for the half-bridge pwm generator
// assumes inclusion by bare name from design files
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH
// -------------------------------------------------
// ccp_control fields
// -------------------------------------------------
`define CCP_MODE_SEL_HI 7
`define CCP_MODE_SEL_LO 6
`define CCP_DUTY_LSB_HI 5
`define CCP_DUTY_LSB_LO 4
`define CCP_MODE_BITS_HI 3
`define CCP_MODE_BITS_LO 0
`define CCP_PWM_MODE 2'h3
`define CCP_CONTROL_RST 8'h00
// -------------------------------------------------
// output modes
// -------------------------------------------------
`define MODE_SINGLE 2'h0
`define MODE_HALF 2'h2
// -------------------------------------------------
// prescale codes and timing
// -------------------------------------------------
`define PRESCALE_1 2'h0
`define PRESCALE_4 2'h1
`define OSC_PER_CYCLE 4
`define PHASE_RST 4'h0
`define PERIOD_LIMIT_RST 8'hff
`define DEADBAND_RST 7'h00
`endif

/* File: design/deadband_delay.v */
// rising-edge delay for one pwm output, counted in instruction cycles
// assumes a one-cycle tick per instruction cycle and active-high input
module deadband_delay #(
	parameter W = 7
) (
	input wire clock,
	input wire nrst,
	input wire run,
	input wire tick,
	input wire [W-1:0] delay,
	input wire raw,
	output reg out
);
	reg [W-1:0] count_reg;
	// -------------------------------------------------
	// delay only the inactive-to-active edge
	// -------------------------------------------------
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_reg <= {W{1'b0}};
			out <= 1'b0;
		end else if (run) begin
			if (!raw) begin
				count_reg <= {W{1'b0}}; // falling edge passes at once
				out <= 1'b0;
			end else if (count_reg == delay) begin
				out <= 1'b1;
			end else if (tick) begin
				count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // deadband_delay

/* File: bench/pwm_checker.sv */
// concurrent checks on the pwm generator's ports
// assumes one clock and an active-low asynchronous reset
module pwm_checker (
	input wire logic clock,
	input wire logic nrst,
	input wire logic sleep,
	input wire logic [7:0] period_limit,
	input wire logic [7:0] duty_msb_reg,
	input wire logic [7:0] ccp_control,
	input wire logic [1:0] pin_direction,
	input wire logic [7:0] base_timer_count,
	input wire logic [7:0] duty_shadow,
	input wire logic timer_period_flag,
	input wire logic output_a_oe,
	input wire logic output_a_owned,
	input wire logic output_b_owned
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// port relations
	// ----
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// rollover raises the flag on the edge that clears the count
	property p_flag; base_timer_count == 8'h00 && $past(base_timer_count) != 8'h00
		|-> timer_period_flag; endproperty
	a_flag: assert property (p_flag) else $error("flag missed");
	property p_step; $changed(base_timer_count) |-> base_timer_count == $past(base_timer_count)
		+ 8'h01 || base_timer_count == 8'h00 && $past(base_timer_count) == $past(period_limit);
		endproperty
	a_step: assert property (p_step) else $error("count step wrong");
	// even at 1:1 each count lasts four clocks
	property p_pace; $changed(base_timer_count) |=> $stable(base_timer_count) [*3]; endproperty
	a_pace: assert property (p_pace) else $error("count too fast");
	property p_shadow; !$stable(duty_shadow) |-> base_timer_count == 8'h00
		&& duty_shadow == $past(duty_msb_reg); endproperty
	a_shadow: assert property (p_shadow) else $error("shadow load wrong");
	property p_sleep; $past(sleep) |-> $stable(base_timer_count) && $stable(duty_shadow);
		endproperty
	a_sleep: assert property (p_sleep) else $error("state moved in sleep");
	property p_oe; output_a_oe |-> !pin_direction[0] && output_a_owned; endproperty
	a_oe: assert property (p_oe) else $error("pin driven while input");
	property p_bown; output_b_owned |-> ccp_control[7:6] == 2'h2 && ccp_control[3:2] == 2'h3;
		endproperty
	a_bown: assert property (p_bown) else $error("second pin taken");
	property p_free; ccp_control == 8'h00 |-> !output_a_owned && !output_b_owned; endproperty
	a_free: assert property (p_free) else $error("pins kept");
endmodule // pwm_checker

bind half_bridge_pwm pwm_checker chk_u (.clock, .nrst, .sleep, .period_limit, .duty_msb_reg,
	.ccp_control, .pin_direction, .base_timer_count, .duty_shadow, .timer_period_flag,
	.output_a_oe, .output_a_owned, .output_b_owned);

/* File: bench/pwm_load.sv */
// load on both pwm pins: pull-down plus high-time counters
// assumes oe is high only while the generator drives
module pwm_load (
	input wire logic clock,
	input wire logic out_a,
	input wire logic oe_a,
	input wire logic out_b,
	input wire logic oe_b,
	output logic pin_a,
	output logic pin_b,
	output int hi_a,
	output int hi_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// released pins fall to the pull-down, so stale levels never count
	// ----
	assign pin_a = oe_a ? out_a : 1'b0;
	assign pin_b = oe_b ? out_b : 1'b0;
	always @(posedge clock) begin
		hi_a <= hi_a + int'(pin_a);
		hi_b <= hi_b + int'(pin_b);
	end
endmodule // pwm_load

/* File: bench/half_bridge_pwm_test.sv */
// self-checking bench for the pwm generator
// assumes a pull-down load and period_limit fixed at 3
`define CHK(n, g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %0d got %0d", n, e, g); end end
module half_bridge_pwm_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, nrst = 1'b0, sleep = 1'b0, timer_run_enable = 1'b0;
	logic timer_flag_clear = 1'b0;
	logic [7:0] period_limit = 8'h03, duty_msb_reg = 8'h00, ccp_control = 8'h00;
	logic [6:0] deadband_count = 7'h00;
	logic [1:0] timer_prescale_sel = 2'h0, pin_direction = 2'h3;
	logic [7:0] base_timer_count, duty_shadow;
	logic timer_period_flag, output_a, output_a_oe, output_b, output_b_oe;
	logic output_a_owned, output_b_owned, pin_a, pin_b;
	int hi_a, hi_b, n_fail = 0, checks = 0, a0, b0, per;
	// ----
	// clock, design and load
	// ----
	always #25 clock = ~clock;
	half_bridge_pwm dut_u (.clock, .nrst, .sleep, .period_limit, .duty_msb_reg, .ccp_control,
		.deadband_count, .timer_prescale_sel, .timer_run_enable, .timer_flag_clear,
		.pin_direction, .base_timer_count, .duty_shadow, .timer_period_flag, .output_a,
		.output_a_oe, .output_b, .output_b_oe, .output_a_owned, .output_b_owned);
	pwm_load load_u (.clock, .out_a(output_a), .oe_a(output_a_oe), .out_b(output_b),
		.oe_b(output_b_oe), .pin_a, .pin_b, .hi_a, .hi_b);
	task finish_test;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task rst_chk;
		nrst <= 1'b0;
		repeat (10) @(posedge clock);
		`CHK("reset", {base_timer_count, duty_shadow, timer_period_flag, output_a_oe,
			output_b_oe}, 19'h0)
		nrst <= 1'b1;
	endtask
	// settle three periods so shadow and deadband catch up, then count two
	task wave(input [1:0] m, input [3:0] mb, input [9:0] d, input [6:0] t, input [1:0] p,
		input int ea, input int eb);
		@(posedge clock);
		ccp_control <= {m, d[1:0], mb};
		duty_msb_reg <= d[9:2];
		deadband_count <= t;
		timer_prescale_sel <= p;
		per = 16 * (p == 2'h0 ? 1 : p == 2'h1 ? 4 : 16);
		repeat (3 * per) @(posedge clock);
		a0 = hi_a;
		b0 = hi_b;
		repeat (2 * per) @(posedge clock);
		`CHK("shadow", duty_shadow, d[9:2])
		`CHK("high a", hi_a - a0, 2 * ea)
		`CHK("high b", hi_b - b0, 2 * eb)
		$display("wave done mode %0h duty %0d", m, d);
	endtask
	initial begin
		rst_chk();
		@(posedge clock);
		ccp_control <= 8'h0c;
		duty_msb_reg <= 8'h01;
		timer_flag_clear <= 1'b1;
		@(posedge clock);
		timer_flag_clear <= 1'b0;
		timer_run_enable <= 1'b1;
		for (int i = 0; i < 40 && timer_period_flag !== 1'b1; i++) @(posedge clock);
		`CHK("flag", timer_period_flag, 1'b1)
		timer_flag_clear <= 1'b1;
		@(posedge clock);
		timer_flag_clear <= 1'b0;
		@(posedge clock);
		`CHK("flag clear", timer_period_flag, 1'b0)
		$display("flag test done");
		pin_direction <= 2'h0;
		wave(2'h0, 4'hc, 10'h000, 7'h00, 2'h0, 0, 0);
		wave(2'h0, 4'hc, 10'h004, 7'h00, 2'h0, 4, 0);
		wave(2'h0, 4'hc, 10'h014, 7'h00, 2'h0, 16, 0);
		wave(2'h0, 4'he, 10'h004, 7'h00, 2'h0, 12, 0);
		wave(2'h0, 4'hc, 10'h008, 7'h00, 2'h1, 32, 0);
		wave(2'h0, 4'hc, 10'h008, 7'h00, 2'h2, 128, 0);
		wave(2'h0, 4'hc, 10'h008, 7'h00, 2'h3, 128, 0);
		wave(2'h2, 4'hc, 10'h008, 7'h00, 2'h0, 8, 8);
		wave(2'h2, 4'hc, 10'h008, 7'h01, 2'h0, 4, 4);
		wave(2'h2, 4'hd, 10'h008, 7'h00, 2'h0, 8, 8);
		wave(2'h2, 4'hc, 10'h004, 7'h02, 2'h0, 0, 4);
		sleep <= 1'b1;
		repeat (3) @(posedge clock);
		a0 = base_timer_count;
		b0 = hi_a + (pin_a ? 40 : 0);
		repeat (40) @(posedge clock);
		`CHK("sleep count", base_timer_count, a0[7:0])
		`CHK("sleep pin", hi_a, b0)
		sleep <= 1'b0;
		ccp_control <= 8'h00;
		repeat (2) @(posedge clock);
		`CHK("released", {output_a_oe, output_b_oe, output_a_owned, output_b_owned}, 4'h0)
		$display("sleep and release done");
		rst_chk();
		finish_test();
	end
	// the tests need about 4000 clocks; a hang stops well past that
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		finish_test();
	end
endmodule // half_bridge_pwm_test
